// ---- rtl/eab_regs.svh ----
// constants for the 8-bit alu and branch unit
`ifndef EAB_REGS_SVH
`define EAB_REGS_SVH

// register port offsets
`define EAB_ADDR_STATUS    4'h0
`define EAB_ADDR_RESULT    4'h1
`define EAB_ADDR_PC_LOW    4'h2
`define EAB_ADDR_PC_HIGH   4'h3

// status register bit positions
`define EAB_FLAG_C         0
`define EAB_FLAG_Z         1
`define EAB_FLAG_N         2
`define EAB_FLAG_V         3
`define EAB_FLAG_S         4
`define EAB_FLAG_H         5
`define EAB_FLAG_T         6
`define EAB_FLAG_I         7

// reset values and byte constants
`define EAB_STATUS_RESET   8'h00
`define EAB_BYTE_ZERO      8'h00
`define EAB_BYTE_ALL       8'hff

// cycle counts per operation
`define EAB_CYC_ONE        3'h1
`define EAB_CYC_TWO        3'h2
`define EAB_CYC_THREE      3'h3
`define EAB_CYC_FOUR       3'h4

// program counter steps
`define EAB_PC_STEP        16'h0001
`define EAB_PC_SKIP_SHORT  16'h0002
`define EAB_PC_SKIP_LONG   16'h0003

`endif

// ---- rtl/eab_pkg.sv ----
// types shared by the 8-bit alu and branch unit
`default_nettype none
package eab_pkg;

  // operations issued by the instruction decoder
  typedef enum logic [4:0] {
    EAB_OP_ADD,
    EAB_OP_ADD_CARRY,
    EAB_OP_ADD_IMMEDIATE_WORD,
    EAB_OP_SUB,
    EAB_OP_SUBTRACT_CONSTANT,
    EAB_OP_SUBTRACT_WITH_CARRY,
    EAB_OP_SUBTRACT_CONSTANT_WITH_CARRY,
    EAB_OP_SUBTRACT_IMMEDIATE_WORD,
    EAB_OP_CONJUNCTION_WITH_CONSTANT,
    EAB_OP_DISJUNCTION_WITH_CONSTANT,
    EAB_OP_SET_BITS_BY_MASK,
    EAB_OP_CLEAR_BITS_BY_MASK,
    EAB_OP_ZERO_SIGN_TEST,
    EAB_OP_COMPARE_WITH_CONSTANT,
    EAB_OP_INDIRECT_JUMP,
    EAB_OP_INDIRECT_SUBROUTINE_CALL,
    EAB_OP_COMPARE_SKIP_EQUAL,
    EAB_OP_SKIP_REGISTER_BIT_CLEAR,
    EAB_OP_SKIP_REGISTER_BIT_SET,
    EAB_OP_SKIP_IO_BIT_CLEAR,
    EAB_OP_SKIP_IO_BIT_SET,
    EAB_OP_BRANCH_STATUS_SET,
    EAB_OP_BRANCH_STATUS_CLEAR,
    EAB_OP_SUBROUTINE_EXIT,
    EAB_OP_INTERRUPT_EXIT
  } eab_op_e;

  // sequencer states
  typedef enum logic {
    EAB_IDLE,
    EAB_RUN
  } eab_state_e;

  // byte adder or subtractor outcome
  typedef struct packed {
    logic [7:0] res;
    logic       c;
    logic       h;
    logic       v;
  } eab_alu_s;

endpackage
`default_nettype wire

// ---- rtl/eab_unit.sv ----
// 8-bit alu and branch unit of the core execution datapath
//
// Contract
// - add with carry writes dst+src+C, sets Z,C,N,V,H, one cycle.
// - word add of constant to register pair, sets Z,C,N,V,S, two cycles.
// - subtract constant writes dst-K, sets Z,C,N,V,H, one cycle.
// - register subtract with carry writes dst-src-C, Z,C,N,V,H, one cycle.
// - constant subtract with carry writes dst-K-C, Z,C,N,V,H, one cycle.
// - word subtract of constant from register pair, Z,C,N,V,S, two cycles.
// - and with constant stores result, one cycle, only Z,N,V change.
// - or with constant stores result, one cycle, only Z,N,V change.
// - set bits ors mask into destination, one cycle, only Z,N,V change.
// - clear bits ands with 0xff minus mask, one cycle, only Z,N,V.
// - test ands register with itself, value kept, Z,N,V in one cycle.
// - indirect jump loads pc from Z pointer, no flags, two cycles.
// - indirect call loads pc from Z pointer, no flags, three cycles.
// - compare skip equal skips next when equal, no flags, 1/2/3 cycles.
// - compare with constant computes dst-K unstored, Z,N,V,C,H, one cycle.
// - skip if register bit clear, no flags, 1/2/3 cycles.
// - skip if register bit set, no flags, 1/2/3 cycles.
// - skip if io bit clear, no flags, 1/2/3 cycles.
// - skip if io bit set, no flags, 1/2/3 cycles.
// - branch if status bit set adds offset+1, 1 or 2 cycles.
// - branch if status bit clear adds offset+1, 1 or 2 cycles.
//
// Strobed register access and the placing of the registers are this design's own decisions.
`default_nettype none
`include "eab_regs.svh"

module eab_unit (
  input  wire logic            CLOCK,
  input  wire logic            NRST,
  input  wire logic            START,
  input  wire eab_pkg::eab_op_e OP,
  input  wire logic [7:0]      DST_VAL,
  input  wire logic [7:0]      DST_HI_VAL,
  input  wire logic [7:0]      SRC_VAL,
  input  wire logic [7:0]      IMM,
  input  wire logic [2:0]      BIT_SEL,
  input  wire logic [7:0]      IO_VAL,
  input  wire logic            NEXT_IS_LONG,
  input  wire logic [6:0]      BR_OFFSET,
  input  wire logic [15:0]     PC_IN,
  input  wire logic [15:0]     Z_PTR,
  input  wire logic [15:0]     STACK_PC,
  input  wire logic [3:0]      ADDR,
  input  wire logic [7:0]      WDATA,
  input  wire logic            WR,
  input  wire logic            RD,
  output var  logic [7:0]      RDATA,
  output logic                 BUSY,
  output logic                 DONE,
  output var  logic [7:0]      RESULT,
  output var  logic [7:0]      RESULT_HI,
  output logic                 RESULT_WE,
  output logic                 RESULT_WORD_WE,
  output var  logic [15:0]     PC_OUT,
  output logic                 PC_LOAD,
  output logic                 PUSH_PC,
  output var  logic [15:0]     RET_ADDR,
  output logic [7:0]           SREG_OUT
);
  import eab_pkg::*;

  // byte add with carry in, flags per bit 3 and bit 7
  function automatic eab_alu_s add8(input logic [7:0] a, input logic [7:0] b,
                                    input logic ci);
    eab_alu_s o;
    o.res = 8'(a + b + {7'h00, ci});
    o.h   = (a[3] & b[3]) | (b[3] & ~o.res[3]) | (~o.res[3] & a[3]);
    o.c   = (a[7] & b[7]) | (b[7] & ~o.res[7]) | (~o.res[7] & a[7]);
    o.v   = (a[7] & b[7] & ~o.res[7]) | (~a[7] & ~b[7] & o.res[7]);
    return o;
  endfunction

  // byte subtract with borrow in
  function automatic eab_alu_s sub8(input logic [7:0] a, input logic [7:0] b,
                                    input logic ci);
    eab_alu_s o;
    o.res = 8'(a - b - {7'h00, ci});
    o.h   = (~a[3] & b[3]) | (b[3] & o.res[3]) | (o.res[3] & ~a[3]);
    o.c   = (~a[7] & b[7]) | (b[7] & o.res[7]) | (o.res[7] & ~a[7]);
    o.v   = (a[7] & ~b[7] & ~o.res[7]) | (~a[7] & b[7] & o.res[7]);
    return o;
  endfunction

  // merge arithmetic flags; zkeep chains zero across the subtract-with-carry forms
  function automatic logic [7:0] arith_flags(input logic [7:0] f, input eab_alu_s r,
                                             input logic zkeep);
    logic [7:0] o;
    o = f;
    o[`EAB_FLAG_Z] = (r.res == `EAB_BYTE_ZERO) & (~zkeep | f[`EAB_FLAG_Z]);
    o[`EAB_FLAG_C] = r.c;
    o[`EAB_FLAG_N] = r.res[7];
    o[`EAB_FLAG_V] = r.v;
    o[`EAB_FLAG_H] = r.h;
    return o;
  endfunction

  // logic result flags, only Z, N and V move
  function automatic logic [7:0] logic_flags(input logic [7:0] f, input logic [7:0] r);
    logic [7:0] o;
    o = f;
    o[`EAB_FLAG_Z] = (r == `EAB_BYTE_ZERO);
    o[`EAB_FLAG_N] = r[7];
    o[`EAB_FLAG_V] = 1'b0;
    return o;
  endfunction

  eab_state_e  state;
  logic [2:0]  cnt;
  logic [7:0]  sreg;
  logic        we_q;
  logic        wwe_q;
  logic        pcld_q;
  logic        push_q;
  logic [7:0]  sreg_q;
  logic [7:0]  next_res;
  logic [7:0]  next_hi;
  logic        next_we;
  logic        next_wwe;
  logic [15:0] next_pc;
  logic        next_pcld;
  logic        next_push;
  logic [7:0]  next_sreg;
  logic [2:0]  next_cyc;
  logic        accept;
  logic        carry;
  eab_alu_s    add_r;
  eab_alu_s    sub_r;
  logic [7:0]  sub_opnd;
  logic [15:0] word;
  logic [15:0] word_sum;
  logic [15:0] word_dif;
  logic [15:0] skip_pc;
  logic [2:0]  skip_cyc;
  logic [15:0] br_pc;

  // operand shaping shared by the arithmetic paths
  assign accept   = START && (state == EAB_IDLE);
  assign carry    = sreg[`EAB_FLAG_C];
  assign add_r    = add8(DST_VAL, SRC_VAL, (OP == EAB_OP_ADD_CARRY) & carry);
  assign sub_opnd = (OP == EAB_OP_SUB || OP == EAB_OP_SUBTRACT_WITH_CARRY) ? SRC_VAL : IMM;
  assign sub_r    = sub8(DST_VAL, sub_opnd, carry & (OP == EAB_OP_SUBTRACT_WITH_CARRY ||
                                           OP == EAB_OP_SUBTRACT_CONSTANT_WITH_CARRY));
  assign word     = {DST_HI_VAL, DST_VAL};
  assign word_sum = word + {8'h00, IMM};
  assign word_dif = word - {8'h00, IMM};
  assign skip_pc  = PC_IN + (NEXT_IS_LONG ? `EAB_PC_SKIP_LONG : `EAB_PC_SKIP_SHORT);
  assign skip_cyc = NEXT_IS_LONG ? `EAB_CYC_THREE : `EAB_CYC_TWO;
  assign br_pc    = PC_IN + {{9{BR_OFFSET[6]}}, BR_OFFSET} + `EAB_PC_STEP;

  // per-operation result, flags, pc and cycle count
  always_comb begin
    next_res  = DST_VAL;
    next_hi   = DST_HI_VAL;
    next_we   = 1'b0;
    next_wwe  = 1'b0;
    next_pc   = PC_IN + `EAB_PC_STEP;
    next_pcld = 1'b0;
    next_push = 1'b0;
    next_sreg = sreg;
    next_cyc  = `EAB_CYC_ONE;
    case (OP)
      EAB_OP_ADD, EAB_OP_ADD_CARRY: begin
        next_res  = add_r.res;
        next_we   = 1'b1;
        next_sreg = arith_flags(sreg, add_r, 1'b0);
      end
      EAB_OP_SUB, EAB_OP_SUBTRACT_CONSTANT: begin
        next_res  = sub_r.res;
        next_we   = 1'b1;
        next_sreg = arith_flags(sreg, sub_r, 1'b0);
      end
      EAB_OP_SUBTRACT_WITH_CARRY, EAB_OP_SUBTRACT_CONSTANT_WITH_CARRY: begin
        next_res  = sub_r.res;
        next_we   = 1'b1;
        next_sreg = arith_flags(sreg, sub_r, 1'b1);
      end
      EAB_OP_COMPARE_WITH_CONSTANT: begin
        next_sreg = arith_flags(sreg, sub_r, 1'b0);
      end
      EAB_OP_ADD_IMMEDIATE_WORD: begin
        {next_hi, next_res}       = word_sum;
        next_wwe                  = 1'b1;
        next_cyc                  = `EAB_CYC_TWO;
        next_sreg[`EAB_FLAG_Z]    = (word_sum == 16'h0000);
        next_sreg[`EAB_FLAG_C]    = ~word_sum[15] & word[15];
        next_sreg[`EAB_FLAG_N]    = word_sum[15];
        next_sreg[`EAB_FLAG_V]    = ~word[15] & word_sum[15];
        next_sreg[`EAB_FLAG_S]    = word_sum[15] ^ (~word[15] & word_sum[15]);
      end
      EAB_OP_SUBTRACT_IMMEDIATE_WORD: begin
        {next_hi, next_res}       = word_dif;
        next_wwe                  = 1'b1;
        next_cyc                  = `EAB_CYC_TWO;
        next_sreg[`EAB_FLAG_Z]    = (word_dif == 16'h0000);
        next_sreg[`EAB_FLAG_C]    = word_dif[15] & ~word[15];
        next_sreg[`EAB_FLAG_N]    = word_dif[15];
        next_sreg[`EAB_FLAG_V]    = word[15] & ~word_dif[15];
        next_sreg[`EAB_FLAG_S]    = word_dif[15] ^ (word[15] & ~word_dif[15]);
      end
      EAB_OP_CONJUNCTION_WITH_CONSTANT: begin
        next_res  = DST_VAL & IMM;
        next_we   = 1'b1;
        next_sreg = logic_flags(sreg, DST_VAL & IMM);
      end
      EAB_OP_DISJUNCTION_WITH_CONSTANT, EAB_OP_SET_BITS_BY_MASK: begin
        next_res  = DST_VAL | IMM;
        next_we   = 1'b1;
        next_sreg = logic_flags(sreg, DST_VAL | IMM);
      end
      EAB_OP_CLEAR_BITS_BY_MASK: begin
        next_res  = DST_VAL & (`EAB_BYTE_ALL - IMM);
        next_we   = 1'b1;
        next_sreg = logic_flags(sreg, DST_VAL & (`EAB_BYTE_ALL - IMM));
      end
      EAB_OP_ZERO_SIGN_TEST: begin
        next_res  = DST_VAL & DST_VAL;
        next_we   = 1'b1;
        next_sreg = logic_flags(sreg, DST_VAL);
      end
      EAB_OP_INDIRECT_JUMP: begin
        next_pc   = Z_PTR;
        next_pcld = 1'b1;
        next_cyc  = `EAB_CYC_TWO;
      end
      EAB_OP_INDIRECT_SUBROUTINE_CALL: begin
        next_pc   = Z_PTR;
        next_pcld = 1'b1;
        next_push = 1'b1;
        next_cyc  = `EAB_CYC_THREE;
      end
      EAB_OP_COMPARE_SKIP_EQUAL, EAB_OP_SKIP_REGISTER_BIT_CLEAR, EAB_OP_SKIP_REGISTER_BIT_SET,
      EAB_OP_SKIP_IO_BIT_CLEAR, EAB_OP_SKIP_IO_BIT_SET: begin
        // skip condition per kind, no flag change
        if ((OP == EAB_OP_COMPARE_SKIP_EQUAL && DST_VAL == SRC_VAL) ||
            (OP == EAB_OP_SKIP_REGISTER_BIT_CLEAR && !DST_VAL[BIT_SEL]) ||
            (OP == EAB_OP_SKIP_REGISTER_BIT_SET && DST_VAL[BIT_SEL]) ||
            (OP == EAB_OP_SKIP_IO_BIT_CLEAR && !IO_VAL[BIT_SEL]) ||
            (OP == EAB_OP_SKIP_IO_BIT_SET && IO_VAL[BIT_SEL])) begin
          next_pc   = skip_pc;
          next_pcld = 1'b1;
          next_cyc  = skip_cyc;
        end
      end
      EAB_OP_BRANCH_STATUS_SET, EAB_OP_BRANCH_STATUS_CLEAR: begin
        // taken when chosen status bit matches the kind
        if (sreg[BIT_SEL] == (OP == EAB_OP_BRANCH_STATUS_SET)) begin
          next_pc   = br_pc;
          next_pcld = 1'b1;
          next_cyc  = `EAB_CYC_TWO;
        end
      end
      EAB_OP_SUBROUTINE_EXIT, EAB_OP_INTERRUPT_EXIT: begin
        next_pc   = STACK_PC;
        next_pcld = 1'b1;
        next_cyc  = `EAB_CYC_FOUR;
        if (OP == EAB_OP_INTERRUPT_EXIT) begin
          next_sreg[`EAB_FLAG_I] = 1'b1;
        end
      end
      default: begin
        next_cyc = `EAB_CYC_ONE;
      end
    endcase
  end

  // sequencer: counts the operation's cycles down to its done cycle
  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      state <= EAB_IDLE;
      cnt   <= 3'h0;
    end else begin
      case (state)
        EAB_IDLE: begin
          if (START) begin
            state <= EAB_RUN;
            cnt   <= next_cyc;
          end
        end
        EAB_RUN: begin
          cnt <= cnt - 3'h1;
          if (cnt == `EAB_CYC_ONE) begin
            state <= EAB_IDLE;
          end
        end
        default: begin
          state <= EAB_IDLE;
        end
      endcase
    end
  end

  // operation results captured when the request is taken
  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      RESULT    <= `EAB_BYTE_ZERO;
      RESULT_HI <= `EAB_BYTE_ZERO;
      PC_OUT    <= 16'h0000;
      RET_ADDR  <= 16'h0000;
      we_q      <= 1'b0;
      wwe_q     <= 1'b0;
      pcld_q    <= 1'b0;
      push_q    <= 1'b0;
      sreg_q    <= `EAB_STATUS_RESET;
    end else if (accept) begin
      RESULT    <= next_res;
      RESULT_HI <= next_hi;
      PC_OUT    <= next_pc;
      RET_ADDR  <= PC_IN + `EAB_PC_STEP;
      we_q      <= next_we;
      wwe_q     <= next_wwe;
      pcld_q    <= next_pcld;
      push_q    <= next_push;
      sreg_q    <= next_sreg;
    end
  end

  // busy flag, done strobes and status output
  assign BUSY           = (state == EAB_RUN);
  assign DONE           = BUSY && (cnt == `EAB_CYC_ONE);
  assign RESULT_WE      = DONE & we_q;
  assign RESULT_WORD_WE = DONE & wwe_q;
  assign PC_LOAD        = DONE & pcld_q;
  assign PUSH_PC        = DONE & push_q;
  assign SREG_OUT       = sreg;

  // status register: hardware commit wins over a software write
  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      sreg <= `EAB_STATUS_RESET;
    end else if (DONE) begin
      sreg <= sreg_q;
    end else if (WR && ADDR == `EAB_ADDR_STATUS) begin
      sreg <= WDATA;
    end
  end

  // read port, data only in the cycle after the strobe
  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      RDATA <= `EAB_BYTE_ZERO;
    end else if (RD) begin
      case (ADDR)
        `EAB_ADDR_STATUS:  RDATA <= sreg;
        `EAB_ADDR_RESULT:  RDATA <= RESULT;
        `EAB_ADDR_PC_LOW:  RDATA <= PC_OUT[7:0];
        `EAB_ADDR_PC_HIGH: RDATA <= PC_OUT[15:8];
        default:           RDATA <= `EAB_BYTE_ZERO;
      endcase
    end else begin
      RDATA <= `EAB_BYTE_ZERO;
    end
  end

  // checks
  property p_adc_one;
    @(posedge CLOCK) disable iff (!NRST)
    (accept && OP == EAB_OP_ADD_CARRY) |=>
      (DONE && RESULT_WE && RESULT == 8'($past(DST_VAL) + $past(SRC_VAL) +
                                          {7'h00, $past(sreg[`EAB_FLAG_C])}));
  endproperty
  a_adc_one: assert property (p_adc_one) else $error("add with carry wrong");

  property p_word_add;
    @(posedge CLOCK) disable iff (!NRST)
    (accept && OP == EAB_OP_ADD_IMMEDIATE_WORD) |=> !DONE ##1
      (RESULT_WORD_WE && {RESULT_HI, RESULT} == $past(word, 2) + {8'h00, $past(IMM, 2)});
  endproperty
  a_word_add: assert property (p_word_add) else $error("word add wrong");

  property p_subtract_constant_carry;
    @(posedge CLOCK) disable iff (!NRST)
    (accept && OP == EAB_OP_SUBTRACT_CONSTANT) |=> DONE ##1
      (sreg[`EAB_FLAG_C] == ($past(DST_VAL, 2) < $past(IMM, 2)));
  endproperty
  a_subtract_constant_carry: assert property (p_subtract_constant_carry) else $error("subtract carry wrong");

  property p_word_sub;
    @(posedge CLOCK) disable iff (!NRST)
    (accept && OP == EAB_OP_SUBTRACT_IMMEDIATE_WORD) |=> !DONE ##1
      (DONE && {RESULT_HI, RESULT} == $past(word, 2) - {8'h00, $past(IMM, 2)});
  endproperty
  a_word_sub: assert property (p_word_sub) else $error("word subtract wrong");

  property p_logic_keep_c;
    @(posedge CLOCK) disable iff (!NRST)
    (accept && !WR && OP == EAB_OP_CONJUNCTION_WITH_CONSTANT) ##1 !WR |=>
      (sreg[`EAB_FLAG_C] == $past(sreg[`EAB_FLAG_C], 2) && RESULT == ($past(DST_VAL, 2) &
       $past(IMM, 2)));
  endproperty
  a_logic_keep_c: assert property (p_logic_keep_c) else $error("and flags wrong");

  property p_indirect_jump;
    @(posedge CLOCK) disable iff (!NRST)
    (accept && OP == EAB_OP_INDIRECT_JUMP) |=> !DONE ##1
      (DONE && PC_LOAD && PC_OUT == $past(Z_PTR, 2));
  endproperty
  a_indirect_jump: assert property (p_indirect_jump) else $error("indirect jump wrong");

  property p_indirect_subroutine_call;
    @(posedge CLOCK) disable iff (!NRST)
    (accept && OP == EAB_OP_INDIRECT_SUBROUTINE_CALL) |=> (!DONE) [*2] ##1 (DONE && PUSH_PC);
  endproperty
  a_indirect_subroutine_call: assert property (p_indirect_subroutine_call) else $error("indirect call wrong");

  property p_cpi;
    @(posedge CLOCK) disable iff (!NRST)
    (accept && OP == EAB_OP_COMPARE_WITH_CONSTANT) |=> (DONE && !RESULT_WE && !PC_LOAD);
  endproperty
  a_cpi: assert property (p_cpi) else $error("compare stored a result");

  property p_skip_clear;
    @(posedge CLOCK) disable iff (!NRST)
    (accept && OP == EAB_OP_SKIP_REGISTER_BIT_CLEAR && !DST_VAL[BIT_SEL] && !NEXT_IS_LONG)
      |=> !DONE ##1 (DONE && PC_LOAD && PC_OUT == $past(PC_IN, 2) + `EAB_PC_SKIP_SHORT);
  endproperty
  a_skip_clear: assert property (p_skip_clear) else $error("bit skip wrong");

  property p_branch;
    @(posedge CLOCK) disable iff (!NRST)
    (accept && OP == EAB_OP_BRANCH_STATUS_SET && !sreg[BIT_SEL]) |=> (DONE && !PC_LOAD);
  endproperty
  a_branch: assert property (p_branch) else $error("untaken branch wrong");

  property p_interrupt_exit;
    @(posedge CLOCK) disable iff (!NRST)
    (accept && OP == EAB_OP_INTERRUPT_EXIT) |=> (!DONE) [*3] ##1 (DONE && PC_LOAD) ##1
      sreg[`EAB_FLAG_I];
  endproperty
  a_interrupt_exit: assert property (p_interrupt_exit) else $error("interrupt exit wrong");

endmodule
`default_nettype wire

// ---- tb/eab_decoder_model.sv ----
// decoder and register file stand-in that issues one operation at a time
`default_nettype none
module eab_decoder_model (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic         go,
  input  wire logic [103:0] req,
  output logic              start,
  output logic [103:0]      opnd
);
  timeunit 1ns;
  timeprecision 100ps;

  // one-cycle strobe; operand lines churn once the request is taken
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      start <= 1'b0;
      opnd  <= '0;
    end else begin
      start <= go;
      opnd  <= go ? req : ~opnd;
    end
  end
endmodule
`default_nettype wire

// ---- tb/eab_unit_bench.sv ----
// self-checking bench for the alu and branch unit
`default_nettype none
module eab_unit_bench;
  import eab_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;

  logic         clk = 1'b0;
  logic         rst_n = 1'b0;
  logic         wr, rd, go, start, busy, done, res_we, word_we, pc_load, push_pc;
  logic         lg, e_ld, e_push;
  logic [3:0]   addr;
  logic [7:0]   wdata, rdata, result, result_hi, sreg, a, h, b, k, io, s, e_sr;
  logic [103:0] req, opnd;
  logic [15:0]  pc_out, ret_addr, pc, z, stk, e_res, e_pc;
  logic [2:0]   bs, e_cyc;
  logic [1:0]   e_wr;
  logic [6:0]   off;
  logic [31:0]  seed = 32'hbf5078e8;
  eab_op_e      op;
  int           error_cnt = 0;
  int           comparisons = 0;

  // unit under test, operands supplied by the decoder stand-in
  eab_unit dut (
    .CLOCK(clk), .NRST(rst_n), .START(start), .OP(eab_op_e'(opnd[103:99])),
    .DST_VAL(opnd[98:91]), .DST_HI_VAL(opnd[90:83]), .SRC_VAL(opnd[82:75]),
    .IMM(opnd[74:67]), .BIT_SEL(opnd[66:64]), .IO_VAL(opnd[63:56]),
    .NEXT_IS_LONG(opnd[55]), .BR_OFFSET(opnd[54:48]), .PC_IN(opnd[47:32]),
    .Z_PTR(opnd[31:16]), .STACK_PC(opnd[15:0]), .ADDR(addr), .WDATA(wdata),
    .WR(wr), .RD(rd), .RDATA(rdata), .BUSY(busy), .DONE(done), .RESULT(result),
    .RESULT_HI(result_hi), .RESULT_WE(res_we), .RESULT_WORD_WE(word_we),
    .PC_OUT(pc_out), .PC_LOAD(pc_load), .PUSH_PC(push_pc), .RET_ADDR(ret_addr),
    .SREG_OUT(sreg)
  );
  eab_decoder_model partner (.clk(clk), .rst_n(rst_n), .go(go), .req(req), .start(start),
                             .opnd(opnd));

  // 40 MHz core clock
  always #12.5 clk = ~clk;

  // repeatable xorshift source
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  // taken transfer: new pc and its cycle count
  function automatic void jump(input logic c, input logic [2:0] n, input logic [15:0] t);
    if (c) begin
      e_ld  = 1'b1;
      e_cyc = n;
      e_pc  = t;
    end
  endfunction

  // skip over a one- or two-word instruction
  function automatic void skip(input logic c);
    jump(c, 3'h2 + {2'b00, lg}, pc + 16'h0002 + {15'h0000, lg});
  endfunction

  // expected outcome of the pending operation
  function automatic void expect_op();
    logic [8:0]  r;
    logic [4:0]  hc;
    logic [16:0] w;
    logic [7:0]  x, y;
    logic        sb, ci, v, zk;
    e_cyc  = 3'h1;
    e_wr   = 2'h0;
    e_ld   = 1'b0;
    e_push = 1'b0;
    e_sr   = s;
    sb = op inside {EAB_OP_SUB, EAB_OP_SUBTRACT_CONSTANT, EAB_OP_SUBTRACT_WITH_CARRY,
                    EAB_OP_SUBTRACT_CONSTANT_WITH_CARRY, EAB_OP_COMPARE_WITH_CONSTANT};
    zk = op inside {EAB_OP_SUBTRACT_WITH_CARRY, EAB_OP_SUBTRACT_CONSTANT_WITH_CARRY};
    ci = s[0] & (zk | (op == EAB_OP_ADD_CARRY));
    x  = (op inside {EAB_OP_ADD, EAB_OP_ADD_CARRY, EAB_OP_SUB,
                     EAB_OP_SUBTRACT_WITH_CARRY}) ? b : k;
    r  = sb ? {1'b0, a} - {1'b0, x} - 9'(ci) : {1'b0, a} + {1'b0, x} + 9'(ci);
    hc = sb ? {1'b0, a[3:0]} - {1'b0, x[3:0]} - 5'(ci)
            : {1'b0, a[3:0]} + {1'b0, x[3:0]} + 5'(ci);
    v  = (sb ^ (a[7] == x[7])) & (r[7] != a[7]);
    w  = (op == EAB_OP_SUBTRACT_IMMEDIATE_WORD) ? {1'b0, h, a} - {9'h000, k}
                                                : {1'b0, h, a} + {9'h000, k};
    case (op)
      EAB_OP_CONJUNCTION_WITH_CONSTANT: y = a & k;
      EAB_OP_CLEAR_BITS_BY_MASK:        y = a & ~k;
      EAB_OP_ZERO_SIGN_TEST:            y = a;
      default:                          y = a | k;
    endcase
    case (op)
      EAB_OP_ADD, EAB_OP_ADD_CARRY, EAB_OP_SUB, EAB_OP_SUBTRACT_CONSTANT,
      EAB_OP_SUBTRACT_WITH_CARRY, EAB_OP_SUBTRACT_CONSTANT_WITH_CARRY,
      EAB_OP_COMPARE_WITH_CONSTANT: begin
        e_res = {8'h00, r[7:0]};
        e_wr  = {1'b0, op != EAB_OP_COMPARE_WITH_CONSTANT};
        e_sr  = {s[7:6], hc[4], s[4], v, r[7], (r[7:0] == 8'h00) & (s[1] | !zk), r[8]};
      end
      EAB_OP_CONJUNCTION_WITH_CONSTANT, EAB_OP_DISJUNCTION_WITH_CONSTANT,
      EAB_OP_SET_BITS_BY_MASK, EAB_OP_CLEAR_BITS_BY_MASK, EAB_OP_ZERO_SIGN_TEST: begin
        e_res = {8'h00, y};
        e_wr  = 2'h1;
        e_sr  = {s[7:4], 1'b0, y[7], y == 8'h00, s[0]};
      end
      EAB_OP_ADD_IMMEDIATE_WORD, EAB_OP_SUBTRACT_IMMEDIATE_WORD: begin
        v     = (h[7] != w[15]) & (h[7] == (op == EAB_OP_SUBTRACT_IMMEDIATE_WORD));
        e_res = w[15:0];
        e_wr  = 2'h2;
        e_cyc = 3'h2;
        e_sr  = {s[7:5], w[15] ^ v, v, w[15], w[15:0] == 16'h0000, w[16]};
      end
      EAB_OP_INDIRECT_JUMP:           jump(1'b1, 3'h2, z);
      EAB_OP_INDIRECT_SUBROUTINE_CALL: begin
        jump(1'b1, 3'h3, z);
        e_push = 1'b1;
      end
      EAB_OP_COMPARE_SKIP_EQUAL:      skip(a == b);
      EAB_OP_SKIP_REGISTER_BIT_CLEAR: skip(!a[bs]);
      EAB_OP_SKIP_REGISTER_BIT_SET:   skip(a[bs]);
      EAB_OP_SKIP_IO_BIT_CLEAR:       skip(!io[bs]);
      EAB_OP_SKIP_IO_BIT_SET:         skip(io[bs]);
      EAB_OP_BRANCH_STATUS_SET:       jump(s[bs], 3'h2, pc + {{9{off[6]}}, off} + 16'h0001);
      EAB_OP_BRANCH_STATUS_CLEAR:     jump(!s[bs], 3'h2, pc + {{9{off[6]}}, off} + 16'h0001);
      EAB_OP_SUBROUTINE_EXIT:         jump(1'b1, 3'h4, stk);
      default: begin
        jump(1'b1, 3'h4, stk);
        e_sr[7] = 1'b1;
      end
    endcase
  endfunction

  // compare and count
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // register port write and read, one strobe cycle each
  task automatic wr_reg(input logic [3:0] ad, input logic [7:0] dt);
    @(posedge clk);
    wr    <= 1'b1;
    addr  <= ad;
    wdata <= dt;
    @(posedge clk);
    wr    <= 1'b0;
  endtask

  task automatic rd_reg(input logic [3:0] ad, output logic [7:0] dt);
    @(posedge clk);
    rd   <= 1'b1;
    addr <= ad;
    @(posedge clk);
    rd   <= 1'b0;
    #1;
    dt = rdata;
  endtask

  // one operation: preset flags, issue, time it, compare every output
  task automatic run_one();
    int         n;
    logic [7:0] d;
    wr_reg(4'h0, s);
    expect_op();
    @(posedge clk);
    go  <= 1'b1;
    req <= {op, a, h, b, k, bs, io, lg, off, pc, z, stk};
    @(posedge clk);
    go  <= 1'b0;
    @(posedge clk);
    n = 1;
    #1;
    while (done !== 1'b1 && n < 8) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk(16'(n), 16'(e_cyc));
    chk(16'(busy), 16'h0001);
    chk(16'({push_pc, pc_load}), 16'({e_push, e_ld}));
    if (e_push) chk(ret_addr, pc + 16'h0001);
    if (e_ld) chk(pc_out, e_pc);
    chk(16'({word_we, res_we}), 16'(e_wr));
    if (e_wr == 2'h1) chk(16'(result), e_res);
    if (e_wr == 2'h2) chk({result_hi, result}, e_res);
    @(posedge clk);
    #1;
    chk(16'(busy), 16'h0000);
    chk(16'(sreg), 16'(e_sr));
    rd_reg(4'h0, d);
    chk(16'(d), 16'(e_sr));
    if (e_wr != 2'h0) begin
      rd_reg(4'h1, d);
      chk(16'(d), 16'(e_res[7:0]));
    end
    if (e_ld) begin
      rd_reg(4'h2, d);
      chk(16'(d), 16'(e_pc[7:0]));
      rd_reg(4'h3, d);
      chk(16'(d), 16'(e_pc[15:8]));
    end
  endtask

  // counts, verdict and end of run
  task automatic complete_run();
    $display("comparisons %0d, mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // hang guard well beyond the expected run length
  initial begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    complete_run();
  end

  // reset, then rounds of every operation with random and corner operands
  initial begin
    wr    = 1'b0;
    rd    = 1'b0;
    go    = 1'b0;
    addr  = 4'h0;
    wdata = 8'h00;
    req   = '0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    #1;
    chk(16'(sreg), 16'h0000);
    for (int rn = 0; rn < 12; rn++) begin
      for (int i = 0; i < 25; i++) begin
        op = eab_op_e'(i);
        {a, h, b, k} = rnd();
        {pc, z} = rnd();
        {stk, io, s} = rnd();
        {off, lg, bs} = 11'(rnd());
        if (rnd() & 32'h1) b = a;
        if (rn == 0) {a, h, b, k, s} = {8'hff, 8'hff, 8'h01, 8'h01, 8'hff};
        if (rn == 1) {a, h, b, k, s} = {8'h00, 8'h00, 8'h80, 8'h01, 8'h03};
        if (op inside {EAB_OP_ADD_IMMEDIATE_WORD, EAB_OP_SUBTRACT_IMMEDIATE_WORD}) k[7:6] = 2'b00;
        run_one();
      end
      $display("round %0d done", rn);
    end
    rd_reg(4'hf, a);
    chk(16'(a), 16'h0000);
    complete_run();
  end
endmodule
`default_nettype wire
